//--- rtl/tasw_pkg.sv
// Package with register map, field layout and mode codes for the switch
package tasw_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] FAST_ROUTING_ADDR = 8'h00;
  localparam logic [7:0] SIDE_ROUTING_ADDR = 8'h01;
  localparam logic [7:0] FAST_ROUTING_RST  = 8'h40;
  localparam logic [7:0] SIDE_ROUTING_RST  = 8'h40;
  localparam logic [7:0] UNMAPPED_RDATA    = 8'h00;

  // ****************************************************************
  // Field layout, same in both registers
  // ****************************************************************
  localparam int ON_BIT    = 6;
  localparam int MODE_HI   = 5;
  localparam int MODE_LO   = 4;
  localparam int PICK_HI   = 3;
  localparam int PICK_LO   = 0;
  localparam int LANES     = 4;
  localparam int CHANNELS  = 16;
  localparam int SEL_W     = LANES * CHANNELS;

  // ****************************************************************
  // Routing modes and strap phase
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_QUAD    = 2'b00,
    MODE_DUAL    = 2'b01,
    MODE_SINGLE  = 2'b10,
    MODE_ILLEGAL = 2'b11
  } tasw_mode_t;

  typedef enum logic {
    PH_STRAP  = 1'b0,
    PH_SERIAL = 1'b1
  } tasw_phase_t;

  // Flat channel index: source in the high pair, channel in the low pair
  function automatic logic [3:0] chan_idx(input logic [1:0] src,
                                          input logic [1:0] ch);
    chan_idx = {src, ch};
  endfunction : chan_idx

  function automatic logic [15:0] one_hot(input logic [3:0] idx);
    one_hot = 16'h0001 << idx;
  endfunction : one_hot

endpackage : tasw_pkg

//--- rtl/tasw_route.sv
// Routing decode: turns enable, mode and source pick into per-lane selects
`timescale 1ns/100ps
module tasw_route #(
  parameter bit SIDE_MAP = 1'b0
) (
  // Configuration
  input  wire logic        on_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [3:0]  pick_i,
  // Lane k owns bits 16k+15 .. 16k, one-hot over channels A0..D3
  output logic      [63:0] lane_sel_o
);

  always_comb begin
    lane_sel_o = '0;
    if (on_i) begin
      case (mode_i)
        tasw_pkg::MODE_QUAD: begin
          // Whole source to lanes 3..0, upper pick bits ignored
          for (int k = 0; k < 4; k++) begin
            lane_sel_o[k*16 +: 16] = tasw_pkg::one_hot(
              tasw_pkg::chan_idx(pick_i[1:0], 2'(k)));
          end
        end
        tasw_pkg::MODE_DUAL: begin
          if (SIDE_MAP) begin
            // A/B pair on lanes 1:0, C/D pair on lanes 3:2
            lane_sel_o[15:0]  = tasw_pkg::one_hot(
              tasw_pkg::chan_idx({1'b0, pick_i[2]}, pick_i[1:0]));
            lane_sel_o[31:16] = lane_sel_o[15:0];
            lane_sel_o[47:32] = tasw_pkg::one_hot(
              tasw_pkg::chan_idx({1'b1, pick_i[2]}, pick_i[1:0]));
            lane_sel_o[63:48] = lane_sel_o[47:32];
          end else begin
            // Lower channel of the pair on lanes 1:0, higher on 3:2
            lane_sel_o[15:0]  = tasw_pkg::one_hot(
              tasw_pkg::chan_idx(pick_i[2:1], {pick_i[0], 1'b0}));
            lane_sel_o[31:16] = lane_sel_o[15:0];
            lane_sel_o[47:32] = tasw_pkg::one_hot(
              tasw_pkg::chan_idx(pick_i[2:1], {pick_i[0], 1'b1}));
            lane_sel_o[63:48] = lane_sel_o[47:32];
          end
        end
        tasw_pkg::MODE_SINGLE: begin
          // One of sixteen, carried on lane 0 only
          lane_sel_o[15:0] = tasw_pkg::one_hot(pick_i);
        end
        default: begin
          lane_sel_o = '0;
        end
      endcase
    end
  end

endmodule : tasw_route

//--- rtl/tasw_switch_ctrl.sv
// Configuration registers and route control for the four-source switch
`timescale 1ns/100ps
// How it works
// - Fast enable low gives standby, lanes off
// - Fast mode 00 quad, 01 dual, 10 single
// - Fast mode write of 11 keeps old mode
// - Quad: pick bits 1:0 choose whole source
// - Dual: bits 2:1 source, bit 0 pair
// - Single: four pick bits choose one channel
// - Side enable low disconnects all side lines
// - Side mode codes match fast mode codes
// - Side mode write of 11 keeps old mode
// - Side quad: pick bits 1:0 choose source
// - Side dual: A/B and C/D line n pairs
// - Side single: four pick bits choose line
// - Fast register at 0x00, resets to 0x40
// - Straps load quad config before serial access
module tasw_switch_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Decoded serial register access
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Strap pins
  input  wire logic        strap_use_i,
  input  wire logic        strap_fast_on_i,
  input  wire logic [1:0]  strap_source_pick_i,
  // Switch controls
  output logic             fast_standby_o,
  output logic      [63:0] fast_lane_sel_o,
  output logic      [63:0] side_common_lines_o
);

  // ****************************************************************
  // Strap synchronisers
  // ****************************************************************
  logic [3:0] strap_meta_r;
  logic [3:0] strap_sync_r;
  logic [3:0] strap_meta_nxt;
  logic [3:0] strap_sync_nxt;

  always_comb begin
    strap_meta_nxt = {strap_use_i, strap_fast_on_i, strap_source_pick_i};
    strap_sync_nxt = strap_meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_meta_r <= 4'h0;
      strap_sync_r <= 4'h0;
    end else begin
      strap_meta_r <= strap_meta_nxt;
      strap_sync_r <= strap_sync_nxt;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  tasw_pkg::tasw_phase_t phase_r;
  tasw_pkg::tasw_phase_t phase_nxt;
  logic [7:0]            fast_path_routing_r;
  logic [7:0]            fast_path_routing_nxt;
  logic [7:0]            side_path_routing_r;
  logic [7:0]            side_path_routing_nxt;
  logic [7:0]            reg_rdata_nxt;
  logic [7:0]            strap_fast_val;
  logic [7:0]            strap_side_val;

  // Enable and pick always land; an illegal mode leaves the old one
  function automatic logic [7:0] apply_write(input logic [7:0] old_v,
                                             input logic [7:0] wr_v);
    logic [1:0] mode;
    mode = wr_v[tasw_pkg::MODE_HI:tasw_pkg::MODE_LO];
    if (mode == tasw_pkg::MODE_ILLEGAL) begin
      mode = old_v[tasw_pkg::MODE_HI:tasw_pkg::MODE_LO];
    end
    apply_write = {1'b0, wr_v[tasw_pkg::ON_BIT], mode,
                   wr_v[tasw_pkg::PICK_HI:tasw_pkg::PICK_LO]};
  endfunction : apply_write

  always_comb begin
    // Strap image: quad mode, side switch on, one pick for both
    strap_fast_val = {1'b0, strap_sync_r[2], tasw_pkg::MODE_QUAD,
                      2'b00, strap_sync_r[1:0]};
    strap_side_val = {1'b0, 1'b1, tasw_pkg::MODE_QUAD,
                      2'b00, strap_sync_r[1:0]};
    phase_nxt             = phase_r;
    fast_path_routing_nxt = fast_path_routing_r;
    side_path_routing_nxt = side_path_routing_r;
    reg_rdata_nxt         = reg_rdata_o;
    if (reg_wr_i || reg_rd_i) begin
      // First serial access closes the strap window for good
      phase_nxt = tasw_pkg::PH_SERIAL;
    end else if (phase_r == tasw_pkg::PH_STRAP && strap_sync_r[3]) begin
      fast_path_routing_nxt = strap_fast_val;
      side_path_routing_nxt = strap_side_val;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        tasw_pkg::FAST_ROUTING_ADDR: begin
          fast_path_routing_nxt = apply_write(fast_path_routing_r,
                                              reg_wdata_i);
        end
        tasw_pkg::SIDE_ROUTING_ADDR: begin
          side_path_routing_nxt = apply_write(side_path_routing_r,
                                              reg_wdata_i);
        end
        default: begin
          fast_path_routing_nxt = fast_path_routing_nxt;
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        tasw_pkg::FAST_ROUTING_ADDR: begin
          reg_rdata_nxt = fast_path_routing_r;
        end
        tasw_pkg::SIDE_ROUTING_ADDR: begin
          reg_rdata_nxt = side_path_routing_r;
        end
        default: begin
          reg_rdata_nxt = tasw_pkg::UNMAPPED_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r             <= tasw_pkg::PH_STRAP;
      fast_path_routing_r <= tasw_pkg::FAST_ROUTING_RST;
      side_path_routing_r <= tasw_pkg::SIDE_ROUTING_RST;
      reg_rdata_o         <= 8'h00;
    end else begin
      phase_r             <= phase_nxt;
      fast_path_routing_r <= fast_path_routing_nxt;
      side_path_routing_r <= side_path_routing_nxt;
      reg_rdata_o         <= reg_rdata_nxt;
    end
  end

  // ****************************************************************
  // Route decode, one instance per switch
  // ****************************************************************
  logic [63:0] fast_sel;
  logic [63:0] side_sel;

  tasw_route #(
    .SIDE_MAP (1'b0)
  ) u_fast_route (
    .on_i       (fast_path_routing_r[tasw_pkg::ON_BIT]),
    .mode_i     (fast_path_routing_r[tasw_pkg::MODE_HI:tasw_pkg::MODE_LO]),
    .pick_i     (fast_path_routing_r[tasw_pkg::PICK_HI:tasw_pkg::PICK_LO]),
    .lane_sel_o (fast_sel)
  );

  // Same mode codes, different dual pairing on the side switch
  tasw_route #(
    .SIDE_MAP (1'b1)
  ) u_side_route (
    .on_i       (side_path_routing_r[tasw_pkg::ON_BIT]),
    .mode_i     (side_path_routing_r[tasw_pkg::MODE_HI:tasw_pkg::MODE_LO]),
    .pick_i     (side_path_routing_r[tasw_pkg::PICK_HI:tasw_pkg::PICK_LO]),
    .lane_sel_o (side_sel)
  );

  // ****************************************************************
  // Registered switch controls
  // ****************************************************************
  logic        fast_standby_nxt;
  logic [63:0] fast_lane_sel_nxt;
  logic [63:0] side_common_lines_nxt;

  always_comb begin
    fast_standby_nxt      = ~fast_path_routing_r[tasw_pkg::ON_BIT];
    fast_lane_sel_nxt     = fast_sel;
    side_common_lines_nxt = side_sel;
  end

  // Registered so switches never see decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_standby_o      <= 1'b0;
      fast_lane_sel_o     <= 64'h0000_0000_0000_0000;
      side_common_lines_o <= 64'h0000_0000_0000_0000;
    end else begin
      fast_standby_o      <= fast_standby_nxt;
      fast_lane_sel_o     <= fast_lane_sel_nxt;
      side_common_lines_o <= side_common_lines_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_fast_standby_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !fast_path_routing_r[6] |=> fast_standby_o && fast_lane_sel_o == '0
  ) else $error("fast lanes not off in standby");

  a_fast_on_lanes: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fast_path_routing_r[6]
    |=> !fast_standby_o && fast_lane_sel_o[15:0] != '0
  ) else $error("fast lanes not on while enabled");

  a_fast_mode_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[5:4] == 2'b11
    |=> fast_path_routing_r[5:4] == $past(fast_path_routing_r[5:4])
        && fast_path_routing_r[3:0] == $past(reg_wdata_i[3:0])
        && fast_path_routing_r[6] == $past(reg_wdata_i[6])
  ) else $error("illegal fast mode write mishandled");

  a_side_mode_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[5:4] == 2'b11
    |=> side_path_routing_r[5:4] == $past(side_path_routing_r[5:4])
        && side_path_routing_r[3:0] == $past(reg_wdata_i[3:0])
        && side_path_routing_r[6] == $past(reg_wdata_i[6])
  ) else $error("illegal side mode write mishandled");

  a_fast_quad_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fast_path_routing_r[6] && fast_path_routing_r[5:4] == 2'b00
    |=> fast_lane_sel_o[63:48] ==
        16'h0001 << {$past(fast_path_routing_r[1:0]), 2'b11}
        && !fast_standby_o
  ) else $error("quad routing lane 3 wrong");

  a_fast_dual_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fast_path_routing_r[6] && fast_path_routing_r[5:4] == 2'b01
    |=> fast_lane_sel_o[47:32] ==
        16'h0001 << {$past(fast_path_routing_r[2:0]), 1'b1}
  ) else $error("dual routing high pair wrong");

  a_fast_single_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fast_path_routing_r[6] && fast_path_routing_r[5:4] == 2'b10
    |=> fast_lane_sel_o[15:0] ==
        16'h0001 << $past(fast_path_routing_r[3:0])
        && fast_lane_sel_o[63:16] == '0
  ) else $error("single routing wrong");

  a_side_off_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !side_path_routing_r[6] |=> side_common_lines_o == '0
  ) else $error("side lines connected while off");

  a_side_quad_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    side_path_routing_r[6] && side_path_routing_r[5:4] == 2'b00
    |=> side_common_lines_o[31:16] ==
        16'h0001 << {$past(side_path_routing_r[1:0]), 2'b01}
  ) else $error("side quad routing lane 1 wrong");

  a_side_dual_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    side_path_routing_r[6] && side_path_routing_r[5:4] == 2'b01
    |=> side_common_lines_o[63:48] == 16'h0001 <<
        {1'b1, $past(side_path_routing_r[2:0])}
        && side_common_lines_o[15:0] == 16'h0001 <<
        {1'b0, $past(side_path_routing_r[2:0])}
  ) else $error("side dual pairing wrong");

  a_side_single_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    side_path_routing_r[6] && side_path_routing_r[5:4] == 2'b10
    |=> side_common_lines_o[15:0] ==
        16'h0001 << $past(side_path_routing_r[3:0])
        && side_common_lines_o[63:16] == '0
  ) else $error("side single routing wrong");

  a_reset_values: assert property (
    @(posedge clk_i)
    $past(rst_i) && rst_i |-> fast_path_routing_r == 8'h40
    && side_path_routing_r == 8'h40 && phase_r == tasw_pkg::PH_STRAP
  ) else $error("reset value wrong");

  a_read_fast: assert property (
    @(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == 8'h00
    |=> reg_rdata_o == $past(fast_path_routing_r)
  ) else $error("fast register read data wrong");

  a_side_write_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h01
    |=> $stable(fast_path_routing_r)
  ) else $error("side write disturbed fast config");

  a_strap_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    phase_r == tasw_pkg::PH_STRAP && strap_sync_r[3]
    && !reg_wr_i && !reg_rd_i
    |=> side_path_routing_r == {6'b010000, $past(strap_sync_r[1:0])}
        && fast_path_routing_r == {1'b0, $past(strap_sync_r[2]),
           4'b0000, $past(strap_sync_r[1:0])}
  ) else $error("strap configuration not loaded");

  a_strap_closed: assert property (
    @(posedge clk_i) disable iff (rst_i)
    phase_r == tasw_pkg::PH_SERIAL && !reg_wr_i
    |=> $stable(fast_path_routing_r) && $stable(side_path_routing_r)
  ) else $error("config changed without a write");

endmodule : tasw_switch_ctrl

//--- testbench/tasw_host_model.sv
// Host controller model driving the decoded register strobes
`timescale 1ns/100ps
module tasw_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register access
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    // Stale data must not look valid once the strobe drops
    reg_wdata_o <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask : read_reg
endmodule : tasw_host_model

//--- testbench/tb.sv
// Self-checking bench for the switch configuration block
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic        clk_i;
  logic        rst_i;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        strap_use;
  logic        strap_fast_on;
  logic [1:0]  strap_pick;
  logic        fast_standby;
  logic [63:0] fast_sel;
  logic [63:0] side_sel;
  logic [7:0]  fast_r;
  logic [7:0]  side_r;
  int          err_count;
  int          num_checks;

  tasw_switch_ctrl dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .strap_use_i(strap_use), .strap_fast_on_i(strap_fast_on),
    .strap_source_pick_i(strap_pick), .fast_standby_o(fast_standby),
    .fast_lane_sel_o(fast_sel), .side_common_lines_o(side_sel));

  tasw_host_model host_u (
    .clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  // ****************************************************************
  // Expectation functions
  // ****************************************************************
  function automatic logic [7:0] upd(input logic [7:0] o, input logic [7:0] d);
    upd = {1'b0, d[6], (d[5:4] == 2'b11) ? o[5:4] : d[5:4], d[3:0]};
  endfunction : upd

  function automatic logic [63:0] exp_sel(input logic [7:0] r, input bit side);
    logic [3:0] idx;
    exp_sel = 64'h0000_0000_0000_0000;
    for (int k = 0; k < 4; k++) begin
      case (r[5:4])
        2'b00:   idx = {r[1:0], 2'(k)};
        2'b01:   idx = side ? {k[1], r[2], r[1:0]} : {r[2:0], k[1]};
        default: idx = r[3:0];
      endcase
      if (r[6] && (r[5:4] != 2'b10 || k == 0))
        exp_sel[16*k +: 16] = 16'h0001 << idx;
    end
  endfunction : exp_sel

  // ****************************************************************
  // Bench tasks
  // ****************************************************************
  task automatic check_out();
    `CHK(fast_standby, ~fast_r[6])
    `CHK(fast_sel, exp_sel(fast_r, 1'b0))
    `CHK(side_sel, exp_sel(side_r, 1'b1))
  endtask : check_out

  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d);
    if (a == 8'h00) fast_r = upd(fast_r, d);
    if (a == 8'h01) side_r = upd(side_r, d);
    @(posedge clk_i);
    #1;
    check_out();
  endtask : do_wr

  task automatic do_rd(input logic [7:0] a);
    logic [7:0] v;
    logic [7:0] e;
    host_u.read_reg(a, v);
    e = (a == 8'h00) ? fast_r : (a == 8'h01) ? side_r : 8'h00;
    `CHK(v, e)
  endtask : do_rd

  task automatic apply_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : apply_reset

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_i         = 1'b1;
    strap_use     = 1'b0;
    strap_fast_on = 1'b0;
    strap_pick    = 2'b00;
    err_count     = 0;
    num_checks    = 0;
    void'($urandom(32'hc2ce1b79));
    fast_r = 8'h40;
    side_r = 8'h40;
    apply_reset();
    @(posedge clk_i);
    #1;
    check_out();
    do_rd(8'h00);
    do_rd(8'h01);
    // Every mode code and pick, side set apart from fast
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 16; p++) begin
        do_wr(8'h00, {1'b0, p != 5, 2'(m), 4'(p)});
        do_wr(8'h01, {1'b0, p != 9, 2'(m ^ 1), ~4'(p)});
        do_rd(8'h00);
        do_rd(8'h01);
      end
    end
    // Illegal code with enable and pick changes in the same byte
    do_wr(8'h00, 8'h5a);
    do_wr(8'h00, 8'h3c);
    do_rd(8'h00);
    repeat (300) begin
      do_wr(8'($urandom_range(0, 2)), 8'($urandom));
      if ($urandom_range(0, 3) == 0) do_rd(8'($urandom_range(0, 3)));
    end
    // Straps load after reset and stop after the first access
    @(posedge clk_i);
    strap_use     <= 1'b1;
    strap_fast_on <= 1'b0;
    strap_pick    <= 2'b10;
    apply_reset();
    repeat (8) @(posedge clk_i);
    #1;
    fast_r = 8'h02;
    side_r = 8'h42;
    check_out();
    // Pins are still followed while no access has come
    @(posedge clk_i);
    strap_fast_on <= 1'b1;
    strap_pick    <= 2'b01;
    repeat (8) @(posedge clk_i);
    #1;
    fast_r = 8'h41;
    side_r = 8'h41;
    check_out();
    do_rd(8'h00);
    @(posedge clk_i);
    strap_fast_on <= 1'b0;
    strap_pick    <= 2'b11;
    repeat (8) @(posedge clk_i);
    #1;
    check_out();
    do_rd(8'h01);
    stop_test();
  end

  initial begin
    #(20 * 20000);
    err_count++;
    stop_test();
  end
endmodule : tb
